/* File: rtl/psc_power_ctrl.sv */
`timescale 1ns/1ps
module psc_power_ctrl
    import psc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic        fast_osc_input,
    input  wire logic        slow_osc_input,
    input  wire logic        amp_ok,
    input  wire logic        wake_pin,
    input  wire logic        halt_disable,
    // Clock outputs
    output logic             fast_osc_enable,
    output logic             slow_osc_enable,
    output logic             core_clk_out,
    output logic             prog_clk_enable,
    output logic             instr_tick
);
    import psc_pkg::*;

    psc_tmr_if tif ();

    // Pin synchronisers
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic       fast_d_ff;
    logic       slow_d_ff;
    logic       wake_d_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_ff   <= '0;
            sync_ff   <= '0;
            fast_d_ff <= 1'b0;
            slow_d_ff <= 1'b0;
            wake_d_ff <= 1'b0;
        end else begin
            meta_ff   <= {halt_disable, wake_pin, amp_ok, slow_osc_input, fast_osc_input};
            sync_ff   <= meta_ff;
            fast_d_ff <= sync_ff[0];
            slow_d_ff <= sync_ff[1];
            wake_d_ff <= sync_ff[3];
        end
    end
    logic fast_lvl;
    logic slow_lvl;
    logic amp_lvl;
    logic halt_dis_lvl;
    logic fast_rise;
    logic slow_rise;
    logic wake_rise;
    assign fast_lvl     = sync_ff[0];
    assign slow_lvl     = sync_ff[1];
    assign amp_lvl      = sync_ff[2];
    assign halt_dis_lvl = sync_ff[4];
    assign fast_rise    = fast_lvl & ~fast_d_ff;
    assign slow_rise    = slow_lvl & ~slow_d_ff;
    assign wake_rise    = sync_ff[3] & ~wake_d_ff;

    // Mode register
    logic [7:0] mode_ff;
    logic       slow_on;
    logic       fast_on;
    logic       tsrc_slow;
    logic       csel_slow;
    logic       eff_tsrc_slow;
    assign slow_on       = mode_ff[PSC_BIT_SLOW_ON];
    assign fast_on       = mode_ff[PSC_BIT_FAST_ON];
    assign tsrc_slow     = mode_ff[PSC_BIT_TSRC];
    assign csel_slow     = mode_ff[PSC_BIT_CSEL];
    // Invalid pairing treated as low speed
    assign eff_tsrc_slow = tsrc_slow | csel_slow;

    function automatic logic [2:0] state_idx(input logic [3:0] nib);
        unique case (nib)
            PSC_ST_HIGH:    state_idx = 3'h0;
            PSC_ST_HI_DUAL: state_idx = 3'h1;
            PSC_ST_DUAL:    state_idx = 3'h2;
            PSC_ST_DUAL_LO: state_idx = 3'h3;
            PSC_ST_LOW:     state_idx = 3'h4;
            default:        state_idx = PSC_IDX_BAD;
        endcase
    endfunction

    // Instruction clock: every fifth fast oscillator edge
    logic [2:0] div_ff;
    logic       itick_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_ff   <= '0;
            itick_ff <= 1'b0;
        end else begin
            itick_ff <= 1'b0;
            if (fast_rise) begin
                if (div_ff == PSC_INSTR_DIV - 3'h1) begin
                    div_ff   <= '0;
                    itick_ff <= 1'b1;
                end else begin
                    div_ff <= div_ff + 3'h1;
                end
            end
        end
    end
    assign instr_tick = itick_ff;

    // AXI4-Lite write side, one write at a time
    logic        aw_ff;
    logic        w_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic        wstrb0_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        wr_go;
    assign s_axi_awready = ~aw_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_ff & ~bvalid_ff;
    assign wr_go         = aw_ff & w_ff & ~bvalid_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= PSC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff      <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_ff     <= 1'b0;
                w_ff      <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (awaddr_ff == PSC_ADDR_MODE || awaddr_ff == PSC_ADDR_HALT ||
                              awaddr_ff == PSC_ADDR_STATUS) ? PSC_RESP_OKAY : PSC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    logic       wr_mode;
    logic       wr_halt;
    logic       wr_stat;
    logic [2:0] idx_old;
    logic [2:0] idx_new;
    logic       step_ok;
    assign wr_mode = wr_go & wstrb0_ff & (awaddr_ff == PSC_ADDR_MODE);
    assign wr_halt = wr_go & wstrb0_ff & (awaddr_ff == PSC_ADDR_HALT);
    assign wr_stat = wr_go & wstrb0_ff & (awaddr_ff == PSC_ADDR_STATUS);
    assign idx_old = state_idx(mode_ff[7:4]);
    assign idx_new = state_idx(wdata_ff[7:4]);
    // Legal and equal or one step away; low to high is four steps
    assign step_ok = (idx_new != PSC_IDX_BAD) &&
                     ((idx_new == idx_old) || (idx_new == idx_old + 3'h1) ||
                      (idx_new + 3'h1 == idx_old));

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_ff <= PSC_MODE_RESET;
        end else if (wr_mode && step_ok) begin
            // Reserved bit 3 held at zero
            mode_ff <= wdata_ff[7:0] & PSC_MODE_WMASK;
        end
    end

    // Halt sequencing
    psc_state_t state_ff;
    psc_state_t nxt_state;
    logic       halt_pend_ff;
    logic       core_tick;
    assign core_tick = csel_slow ? slow_rise : itick_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            halt_pend_ff <= 1'b0;
        end else if (state_ff != PSC_RUN) begin
            halt_pend_ff <= 1'b0;
        end else if (wr_halt && wdata_ff[PSC_BIT_HALT] && !halt_dis_lvl) begin
            halt_pend_ff <= 1'b1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PSC_RUN:  if (halt_pend_ff && core_tick) nxt_state = PSC_HALT;
            PSC_HALT: if (wake_rise) nxt_state = PSC_WAKE;
            PSC_WAKE: if (tif.underflow) nxt_state = PSC_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= PSC_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Idle timer hookup
    assign tif.load    = (state_ff == PSC_HALT) && wake_rise;
    assign tif.win_sel = mode_ff[2:0];
    always_comb begin
        unique case (state_ff)
            PSC_RUN:  tif.tick = eff_tsrc_slow ? slow_rise : itick_ff;
            PSC_HALT: tif.tick = 1'b0;
            PSC_WAKE: tif.tick = itick_ff & amp_lvl;
            default:  tif.tick = 1'b0;
        endcase
    end

    psc_idle_timer u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .tif      (tif)
    );

    // Window flag, write one to clear, set wins
    logic win_flag_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            win_flag_ff <= 1'b0;
        end else if (tif.window_evt) begin
            win_flag_ff <= 1'b1;
        end else if (wr_stat && wdata_ff[2]) begin
            win_flag_ff <= 1'b0;
        end
    end

    // Oscillator and core clock outputs
    logic fast_en_ff;
    logic slow_en_ff;
    logic prog_en_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fast_en_ff <= 1'b1;
            slow_en_ff <= 1'b0;
            prog_en_ff <= 1'b1;
        end else begin
            // Wake forces the fast oscillator for the start-up count
            fast_en_ff <= (fast_on && nxt_state == PSC_RUN) || nxt_state == PSC_WAKE;
            slow_en_ff <= slow_on;
            prog_en_ff <= nxt_state == PSC_RUN;
        end
    end
    assign fast_osc_enable = fast_en_ff;
    assign slow_osc_enable = slow_en_ff;
    assign prog_clk_enable = prog_en_ff;

    psc_clk_mux u_mux (
        .core_clk (core_clk),
        .rst      (rst),
        .fast_lvl (fast_lvl),
        .slow_lvl (slow_lvl),
        .sel_slow (csel_slow),
        .run      (state_ff == PSC_RUN),
        .clk_out  (core_clk_out)
    );

    // AXI4-Lite read side
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= PSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= PSC_RESP_OKAY;
            unique case (s_axi_araddr)
                PSC_ADDR_MODE:   rdata_ff <= {24'h000000, mode_ff};
                PSC_ADDR_HALT:   rdata_ff <= {24'h000000, state_ff != PSC_RUN, 7'h00};
                PSC_ADDR_STATUS: rdata_ff <= {28'h0000000, eff_tsrc_slow, win_flag_ff,
                                              state_ff == PSC_WAKE, state_ff == PSC_HALT};
                default: begin
                    rdata_ff <= '0;
                    rresp_ff <= PSC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // Checks
    sequence s_halted;
        state_ff == PSC_HALT;
    endsequence
    sequence s_woken;
        state_ff == PSC_HALT ##1 state_ff == PSC_WAKE;
    endsequence

    a_reset_mode_val: assert property (@(posedge core_clk)
        rst |=> mode_ff == PSC_MODE_RESET) else $error("mode not 40 after reset");
    a_mode_legal: assert property (@(posedge core_clk) disable iff (rst)
        state_idx(mode_ff[7:4]) != PSC_IDX_BAD) else $error("illegal mode nibble");
    a_bad_write_kept: assert property (@(posedge core_clk) disable iff (rst)
        wr_mode && !step_ok |=> $stable(mode_ff)) else $error("refused write changed mode");
    a_no_low_to_high: assert property (@(posedge core_clk) disable iff (rst)
        mode_ff[7:4] == PSC_ST_LOW |=> mode_ff[7:4] != PSC_ST_HIGH)
        else $error("low speed jumped to high speed");
    a_halt_stops_fast: assert property (@(posedge core_clk) disable iff (rst)
        s_halted |-> !fast_osc_enable && !prog_clk_enable)
        else $error("fast oscillator running in halt");
    a_halt_disabled: assert property (@(posedge core_clk) disable iff (rst)
        halt_dis_lvl && state_ff == PSC_RUN && !halt_pend_ff |=> !halt_pend_ff)
        else $error("halt taken while disabled");
    a_wake_delay: assert property (@(posedge core_clk) disable iff (rst)
        s_woken |-> !prog_clk_enable [*8]) else $error("program clock early after wake");
    a_wake_gated: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == PSC_WAKE && !amp_lvl |-> !tif.tick)
        else $error("wake count without amplitude");
    a_forced_low: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == PSC_RUN && csel_slow |-> tif.tick == slow_rise)
        else $error("timer not slow with core slow");
endmodule // psc_power_ctrl

/* File: rtl/psc_pkg.sv */
// Functional notes
// - Reset loads mode register with 40 hex
// - Bit 7 runs or stops slow oscillator
// - Bit 6 runs or stops fast oscillator
// - Bit 5 picks idle timer clock source
// - Bit 4 picks core clock source
// - Timer fast with core slow forces low speed
// - Low three bits select idle timer window
// - Only five legal upper-nibble states, in order
// - Non-adjacent state writes ignored, register unchanged
// - Any reset leaves high speed mode
// - Low speed to high speed only via dual
// - Halt bit 7 write enters halt on the next core tick
// - High speed halt stops clock and oscillator
// - Reset leaves halt, restarts with reset values
// - Wake-up transition ends halt, always delayed
// - Wake loads timer 256, clocks after underflow
// - Instruction clock is fast oscillator over five
// - Wake delay counts only with enough amplitude
// - Halt-disable option ignores halt requests
// - Window field selects 4k to 64k cycles
package psc_pkg;
    // Register byte addresses
    localparam logic [11:0] PSC_ADDR_MODE   = 12'h000;
    localparam logic [11:0] PSC_ADDR_HALT   = 12'h004;
    localparam logic [11:0] PSC_ADDR_STATUS = 12'h008;
    // Mode register layout
    localparam logic [7:0]  PSC_MODE_RESET  = 8'h40;
    localparam int          PSC_BIT_SLOW_ON = 7;
    localparam int          PSC_BIT_FAST_ON = 6;
    localparam int          PSC_BIT_TSRC    = 5;
    localparam int          PSC_BIT_CSEL    = 4;
    localparam logic [7:0]  PSC_MODE_WMASK  = 8'hF7;
    localparam int          PSC_BIT_HALT    = 7;
    // Legal upper-nibble states in sequence order
    localparam logic [3:0]  PSC_ST_HIGH     = 4'h4;
    localparam logic [3:0]  PSC_ST_HI_DUAL  = 4'hC;
    localparam logic [3:0]  PSC_ST_DUAL     = 4'hE;
    localparam logic [3:0]  PSC_ST_DUAL_LO  = 4'hF;
    localparam logic [3:0]  PSC_ST_LOW      = 4'hB;
    localparam logic [2:0]  PSC_IDX_BAD     = 3'h7;
    // Timing
    localparam logic [2:0]  PSC_INSTR_DIV   = 3'h5;
    localparam logic [16:0] PSC_WAKE_COUNT  = 17'h00100;
    localparam int          PSC_WIN_BASE    = 12;
    localparam logic [2:0]  PSC_WIN_MAX     = 3'h4;
    localparam int          PSC_TMR_W       = 17;
    // Bus answers
    localparam logic [1:0]  PSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PSC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PSC_RUN  = 3'b001,
        PSC_HALT = 3'b010,
        PSC_WAKE = 3'b100
    } psc_state_t;
endpackage

/* File: rtl/psc_tmr_if.sv */
`timescale 1ns/1ps
interface psc_tmr_if;
    logic       tick;
    logic       load;
    logic [2:0] win_sel;
    logic       window_evt;
    logic       underflow;
    modport timer (input tick, input load, input win_sel, output window_evt, output underflow);
    modport ctrl  (output tick, output load, output win_sel, input window_evt, input underflow);
endinterface

/* File: rtl/psc_idle_timer.sv */
`timescale 1ns/1ps
module psc_idle_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control side
    psc_tmr_if.timer tif
);
    import psc_pkg::*;

    logic [PSC_TMR_W-1:0] cnt_ff;
    logic [PSC_TMR_W-1:0] nxt_cnt;
    logic                 window_ff;
    logic                 under_ff;
    logic [2:0]           sel;

    assign sel     = (tif.win_sel > PSC_WIN_MAX) ? PSC_WIN_MAX : tif.win_sel;
    assign nxt_cnt = cnt_ff - 17'h00001;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (tif.load) begin
            cnt_ff <= PSC_WAKE_COUNT;
        end else if (tif.tick) begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Window tap toggles once per 2^(12+sel) ticks
    always_ff @(posedge core_clk) begin
        if (rst) begin
            window_ff <= 1'b0;
            under_ff  <= 1'b0;
        end else begin
            window_ff <= tif.tick & ~tif.load &
                         (cnt_ff[PSC_WIN_BASE+sel] ^ nxt_cnt[PSC_WIN_BASE+sel]);
            under_ff  <= tif.tick & ~tif.load & (cnt_ff == 17'h00001);
        end
    end

    assign tif.window_evt = window_ff;
    assign tif.underflow  = under_ff;

    a_load_no_under: assert property (@(posedge core_clk) disable iff (rst)
        tif.load |=> !tif.underflow [*8]) else $error("underflow right after load");
endmodule // psc_idle_timer

/* File: rtl/psc_clk_mux.sv */
`timescale 1ns/1ps
module psc_clk_mux (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Sources, already synchronised
    input  wire logic fast_lvl,
    input  wire logic slow_lvl,
    // Control
    input  wire logic sel_slow,
    input  wire logic run,
    // Gated core clock
    output logic      clk_out
);
    logic en_fast_ff;
    logic en_slow_ff;
    logic clk_ff;

    // Enables move only while own source is low, never both on
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_fast_ff <= 1'b0;
            en_slow_ff <= 1'b0;
        end else begin
            if (!fast_lvl) begin
                en_fast_ff <= run & ~sel_slow & ~en_slow_ff;
            end
            if (!slow_lvl) begin
                en_slow_ff <= run & sel_slow & ~en_fast_ff;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_ff <= 1'b0;
        end else begin
            clk_ff <= (fast_lvl & en_fast_ff) | (slow_lvl & en_slow_ff);
        end
    end

    assign clk_out = clk_ff;

    a_mux_one_hot: assert property (@(posedge core_clk) disable iff (rst)
        !(en_fast_ff && en_slow_ff)) else $error("both clock enables on");
    a_mux_en_stable: assert property (@(posedge core_clk) disable iff (rst)
        fast_lvl && $past(fast_lvl) |-> $stable(en_fast_ff))
        else $error("fast enable moved while source high");
endmodule // psc_clk_mux

/* File: dv/test_psc_power_ctrl.sv */
`timescale 1ns/1ps
module test_psc_power_ctrl;
    import psc_pkg::*;
    typedef struct packed {
        logic [7:0] wr;
        logic [7:0] mode;
        logic       fast;
        logic       slow;
    } psc_row_t;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        amp_ok = 1'b1, wake_pin = 1'b0, halt_disable = 1'b0;
    logic        fast_osc_enable, slow_osc_enable, core_clk_out, prog_clk_enable, instr_tick;
    logic [1:0]  fdiv = 2'h0;
    logic [3:0]  sdiv = 4'h0;
    wire         fast_osc_input = fdiv[1];
    wire         slow_osc_input = sdiv[3];
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          hi_run = 0;

    psc_row_t rows [13] = '{
        '{8'h80, 8'h40, 1'b1, 1'b0}, '{8'hE0, 8'h40, 1'b1, 1'b0},
        '{8'hCB, 8'hC3, 1'b1, 1'b1}, '{8'hB0, 8'hC3, 1'b1, 1'b1},
        '{8'hE4, 8'hE4, 1'b1, 1'b1}, '{8'hF2, 8'hF2, 1'b1, 1'b1},
        '{8'hB1, 8'hB1, 1'b0, 1'b1}, '{8'h40, 8'hB1, 1'b0, 1'b1},
        '{8'hE0, 8'hB1, 1'b0, 1'b1}, '{8'hF0, 8'hF0, 1'b1, 1'b1},
        '{8'hE0, 8'hE0, 1'b1, 1'b1}, '{8'hC0, 8'hC0, 1'b1, 1'b1},
        '{8'h40, 8'h40, 1'b1, 1'b0}};

    psc_power_ctrl psc_power_ctrl_i (
        .core_clk, .rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready,
        .fast_osc_input, .slow_osc_input, .amp_ok, .wake_pin, .halt_disable,
        .fast_osc_enable, .slow_osc_enable, .core_clk_out, .prog_clk_enable, .instr_tick
    );

    always #50 core_clk = ~core_clk;

    // Oscillators swing only while enabled, so a halted fast source really stops
    always @(posedge core_clk) begin
        if (fast_osc_enable === 1'b1) fdiv <= fdiv + 2'h1;
        if (slow_osc_enable === 1'b1) sdiv <= sdiv + 4'h1;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic fail(input string m);
        bad_count++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (core_clk_out === 1'b1) hi_run++;
        else begin
            // A high pulse shorter than a fast half period means a switching glitch
            if (hi_run == 1) fail("short core clock pulse");
            hi_run = 0;
        end
        if (cyc == 30000) begin
            fail("timeout");
            print_verdict();
        end
    end

    // Waits as long as the slave needs; only the bench timeout ends a hang
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // Cycles between two rising edges of the core clock or of the tick
    task automatic rise_gap(input logic use_tick, output int p);
        logic q;
        int   n;
        q = 1'b1;
        p = 0;
        n = 0;
        while (n < 2 && p < 200) begin
            @(posedge core_clk);
            p++;
            if ((use_tick ? instr_tick : core_clk_out) === 1'b1 && q === 1'b0) begin
                n++;
                if (n == 1) p = 0;
            end
            q = use_tick ? instr_tick : core_clk_out;
        end
    endtask

    initial begin
        logic [31:0] rd;
        logic [1:0]  rs;
        int          n;
        int          k;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        axi_read(PSC_ADDR_MODE, rd, rs);
        chk(rd, 32'h40, "mode after reset");
        chk({fast_osc_enable, slow_osc_enable, prog_clk_enable}, 3'b101, "reset pins");
        $display("Test reset done");
        foreach (rows[i]) begin
            axi_write(PSC_ADDR_MODE, {24'h0, rows[i].wr}, rs);
            chk(rs, PSC_RESP_OKAY, "mode write resp");
            axi_read(PSC_ADDR_MODE, rd, rs);
            chk(rd, {24'h0, rows[i].mode}, "mode readback");
            chk(fast_osc_enable, rows[i].fast, "fast enable");
            chk(slow_osc_enable, rows[i].slow, "slow enable");
            axi_read(PSC_ADDR_STATUS, rd, rs);
            chk(rd[3], rows[i].mode[5], "timer source");
            // Give the new source time to settle before timing it
            repeat (40) @(posedge core_clk);
            rise_gap(1'b0, k);
            chk(k, rows[i].mode[4] ? 16 : 4, "core clock period");
        end
        $display("Test mode table done");
        axi_read(12'h00C, rd, rs);
        chk(rd, 32'h0, "unmapped read data");
        chk({30'h0, rs}, {30'h0, PSC_RESP_SLVERR}, "unmapped read resp");
        axi_write(12'h010, 32'h0, rs);
        chk(rs, PSC_RESP_SLVERR, "unmapped write");
        rise_gap(1'b1, k);
        chk(k, 20, "instruction tick period");
        $display("Test bus and tick done");
        halt_disable <= 1'b1;
        repeat (4) @(posedge core_clk);
        axi_write(PSC_ADDR_HALT, 32'h80, rs);
        repeat (100) @(posedge core_clk);
        chk(prog_clk_enable, 1'b1, "halt ignored");
        halt_disable <= 1'b0;
        repeat (4) @(posedge core_clk);
        axi_write(PSC_ADDR_HALT, 32'h80, rs);
        repeat (2) @(posedge core_clk);
        n = 0;
        while (prog_clk_enable !== 1'b0 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        chk({prog_clk_enable, fast_osc_enable}, 2'b00, "halted");
        axi_read(PSC_ADDR_HALT, rd, rs);
        chk(rd[7], 1'b1, "halt flag");
        amp_ok <= 1'b0;
        wake_pin <= 1'b1;
        repeat (300) @(posedge core_clk);
        chk(prog_clk_enable, 1'b0, "no count without swing");
        axi_read(PSC_ADDR_STATUS, rd, rs);
        chk(rd[1:0], 2'b10, "wake delay status");
        n = 0;
        while (instr_tick !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        amp_ok <= 1'b1;
        k = 0;
        n = 0;
        while (prog_clk_enable !== 1'b1 && n < 8000) begin
            @(posedge core_clk);
            if (instr_tick === 1'b1) k++;
            n++;
        end
        chk(k, 256, "wake delay ticks");
        wake_pin <= 1'b0;
        $display("Test halt and wake done");
        axi_write(PSC_ADDR_MODE, 32'hC4, rs);
        axi_write(PSC_ADDR_HALT, 32'h80, rs);
        n = 0;
        while (prog_clk_enable !== 1'b0 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk({prog_clk_enable, fast_osc_enable}, 2'b11, "reset leaves halt");
        axi_read(PSC_ADDR_MODE, rd, rs);
        chk(rd, 32'h40, "mode after halt reset");
        $display("Test reset in halt done");
        print_verdict();
    end
endmodule // test_psc_power_ctrl
